// File: ethc_pkg.sv
// Purpose: Shared constants and carriers for the Ethernet header comparator.
// Assumes: One clock domain; AXI4-Lite register access with 32-bit data.
// Notes:   Register offsets are byte addresses of aligned words.
package ethc_pkg;

    // ----------------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------------
    localparam logic [7:0] ETHC_REG_CTRL = 8'h00;
    localparam logic [7:0] ETHC_REG_STAG = 8'h04;
    localparam logic [7:0] ETHC_REG_ETYPE = 8'h08;
    localparam logic [7:0] ETHC_REG_VLAN = 8'h0C;
    localparam logic [7:0] ETHC_REG_LEN = 8'h10;
    localparam logic [7:0] ETHC_REG_ITAG = 8'h14;
    localparam logic [7:0] ETHC_REG_STATUS = 8'h18;
    localparam int ETHC_ADDR_W = 8;

    // Control word field positions.
    localparam int CTRL_NEXT_LSB = 0;
    localparam int CTRL_SIG_LSB = 4;
    localparam int CTRL_PBB_BIT = 12;
    localparam int CTRL_ETYPE_BIT = 16;
    localparam int CTRL_LEN_BIT = 20;
    localparam int CTRL_VLAN_BIT = 24;
    localparam int VLAN_MASK_LSB = 16;
    localparam int LEN_HI_LSB = 16;

    // Reset values.
    localparam logic [15:0] ETHC_STAG_RESET = 16'h8A88;
    localparam logic [15:0] ETHC_ITAG_RESET = 16'h0000;
    localparam logic [15:0] ETHC_ETYPE_RESET = 16'h0000;
    localparam logic [2:0] ETHC_NEXT_RESET = 3'h5;

    // ----------------------------------------------------------------------
    // Frame constants
    // ----------------------------------------------------------------------
    localparam logic [15:0] ETHC_CTAG_TYPE = 16'h8100;
    localparam logic [15:0] ETHC_LEN_LIMIT = 16'h0600;
    localparam logic [7:0] ETHC_SAP_A = 8'hAA;
    localparam logic [7:0] ETHC_SAP_B = 8'hAB;
    localparam logic [7:0] ETHC_LLC_CTL = 8'h03;
    localparam logic [23:0] ETHC_OUI_ZERO = 24'h000000;
    localparam logic [23:0] ETHC_OUI_ALT = 24'h0000F8;
    localparam logic [2:0] ETHC_ADDR_LAST = 3'h5;
    localparam logic [2:0] ETHC_LLC_LAST = 3'h2;
    localparam logic [2:0] ETHC_OUI_LAST = 3'h2;
    localparam logic [2:0] ETHC_ITAG_LAST = 3'h3;
    localparam logic [2:0] ETHC_PAIR_LAST = 3'h1;
    localparam logic [1:0] ETHC_MAX_TAGS = 2'h2;
    localparam logic [2:0] ETHC_STAGE_FIRST = 3'h0;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // ----------------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_TYPE = 4'h3,
        ST_TAG = 4'h2,
        ST_LLC = 4'h6,
        ST_OUI = 4'h7,
        ST_ITAG = 4'h5,
        ST_DONE = 4'h4,
        ST_FAIL = 4'hC
    } ethc_state_t;

    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] data;
    } ethc_byte_t;

    typedef struct packed {
        logic valid;
        logic ok;
        logic noModify;
        logic [5:0] offset;
        logic [2:0] nextStage;
        logic [4:0] sigOffset;
    } ethc_result_t;

    typedef struct packed {
        logic awvalid;
        logic [ETHC_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ETHC_ADDR_W-1:0] araddr;
        logic rready;
    } ethc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ethc_axi_rsp_t;

endpackage

// File: ethc_header_comparator.sv
// Purpose: Ethernet/LLC/SNAP next-protocol header comparator stage.
// Assumes: Header bytes arrive aligned, one per valid cycle, byte 0 on sof.
// Notes:   Registers are reached over AXI4-Lite.
`timescale 1ns/100ps

module ethc_header_comparator #(
    parameter bit FIRST_STAGE = 1'b1
) (
    input wire logic mclk,
    input wire logic reset,
    input wire ethc_pkg::ethc_byte_t hdrIn,
    input wire logic flowHit,
    output ethc_pkg::ethc_result_t result,
    input wire ethc_pkg::ethc_axi_req_t axiReq,
    output ethc_pkg::ethc_axi_rsp_t axiRsp
);
    import ethc_pkg::*;

    // ----------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------
    typedef struct packed {
        // Register file.
        logic [2:0] nextStage;
        logic [4:0] sigOffset;
        logic pbbEnable;
        logic etypeEnable;
        logic lenEnable;
        logic vlanEnable;
        logic [15:0] stagType;
        logic [15:0] etypeValue;
        logic [11:0] vlanMatch;
        logic [11:0] vlanMask;
        logic [15:0] lenLo;
        logic [15:0] lenHi;
        logic [15:0] itagType;
        // Bus slave.
        logic awHeld;
        logic [ETHC_ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        // Parser.
        ethc_state_t state;
        logic [5:0] cnt;
        logic [2:0] fld;
        logic [15:0] word;
        logic [1:0] tags;
        logic llc;
        logic lastOk;
        logic lastFail;
        logic [5:0] lastOffset;
        ethc_result_t res;
    } ethc_regs_t;

    ethc_regs_t cur;
    ethc_regs_t next_cur;

    function automatic logic [31:0] mergeBytes(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return m;
    endfunction

    function automatic logic [31:0] readReg(
        input ethc_regs_t r,
        input logic [ETHC_ADDR_W-1:0] a
    );
        logic [31:0] v;
        v = 32'h00000000;
        case (a)
            ETHC_REG_CTRL: begin
                v[CTRL_NEXT_LSB +: 3] = r.nextStage;
                v[CTRL_SIG_LSB +: 5] = r.sigOffset;
                v[CTRL_PBB_BIT] = r.pbbEnable;
                v[CTRL_ETYPE_BIT] = r.etypeEnable;
                v[CTRL_LEN_BIT] = r.lenEnable;
                v[CTRL_VLAN_BIT] = r.vlanEnable;
            end
            ETHC_REG_STAG: v[15:0] = r.stagType;
            ETHC_REG_ETYPE: v[15:0] = r.etypeValue;
            ETHC_REG_VLAN: begin
                v[11:0] = r.vlanMatch;
                v[VLAN_MASK_LSB +: 12] = r.vlanMask;
            end
            ETHC_REG_LEN: v = {r.lenHi, r.lenLo};
            ETHC_REG_ITAG: v[15:0] = r.itagType;
            ETHC_REG_STATUS: v = {16'h0000, r.lastFail, r.lastOk,
                                  r.state, 4'h0, r.lastOffset};
            default: v = 32'h00000000;
        endcase
        return v;
    endfunction

    function automatic logic isMapped(input logic [ETHC_ADDR_W-1:0] a);
        return a == ETHC_REG_CTRL || a == ETHC_REG_STAG ||
               a == ETHC_REG_ETYPE || a == ETHC_REG_VLAN ||
               a == ETHC_REG_LEN || a == ETHC_REG_ITAG ||
               a == ETHC_REG_STATUS;
    endfunction

    // ----------------------------------------------------------------------
    // Bus handshakes
    // ----------------------------------------------------------------------
    // A new write is held off while its response is still pending.
    always_comb begin
        axiRsp.awready = !cur.awHeld && !cur.bValid;
        axiRsp.wready = !cur.wHeld && !cur.bValid;
        axiRsp.bvalid = cur.bValid;
        axiRsp.bresp = cur.bResp;
        axiRsp.arready = !cur.rValid;
        axiRsp.rvalid = cur.rValid;
        axiRsp.rdata = cur.rData;
        axiRsp.rresp = cur.rResp;
    end

    assign result = cur.res;

    // ----------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------
    always_comb begin
        logic [31:0] wv;
        logic [15:0] w;
        logic [11:0] vid;
        logic [23:0] oui;
        logic pbb;
        logic finish;
        logic fail;
        logic isC;
        logic isS;
        logic isI;
        wv = 32'h00000000;
        w = {cur.word[7:0], hdrIn.data};
        vid = {cur.word[3:0], hdrIn.data};
        oui = {cur.word, hdrIn.data};
        // Bridging can never be active in the second stage.
        pbb = FIRST_STAGE && cur.pbbEnable;
        finish = 1'b0;
        fail = 1'b0;
        isC = (w == ETHC_CTAG_TYPE);
        isS = (w == cur.stagType);
        isI = pbb && (w == cur.itagType);
        next_cur = cur;
        next_cur.res.valid = 1'b0;
        next_cur.res.noModify = 1'b0;

        // AXI4-Lite write: address and data accepted in either order.
        if (axiReq.awvalid && axiRsp.awready) begin
            next_cur.awHeld = 1'b1;
            next_cur.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && axiRsp.wready) begin
            next_cur.wHeld = 1'b1;
            next_cur.wData = axiReq.wdata;
            next_cur.wStrb = axiReq.wstrb;
        end
        if (cur.awHeld && cur.wHeld) begin
            next_cur.awHeld = 1'b0;
            next_cur.wHeld = 1'b0;
            next_cur.bValid = 1'b1;
            next_cur.bResp = AXI_OKAY;
            wv = mergeBytes(readReg(cur, cur.awAddr), cur.wData, cur.wStrb);
            case (cur.awAddr)
                ETHC_REG_CTRL: begin
                    next_cur.nextStage = wv[CTRL_NEXT_LSB +: 3];
                    next_cur.sigOffset = wv[CTRL_SIG_LSB +: 5];
                    next_cur.pbbEnable = wv[CTRL_PBB_BIT] && FIRST_STAGE;
                    next_cur.etypeEnable = wv[CTRL_ETYPE_BIT];
                    next_cur.lenEnable = wv[CTRL_LEN_BIT];
                    next_cur.vlanEnable = wv[CTRL_VLAN_BIT];
                end
                ETHC_REG_STAG: next_cur.stagType = wv[15:0];
                ETHC_REG_ETYPE: next_cur.etypeValue = wv[15:0];
                ETHC_REG_VLAN: begin
                    next_cur.vlanMatch = wv[11:0];
                    next_cur.vlanMask = wv[VLAN_MASK_LSB +: 12];
                end
                ETHC_REG_LEN: begin
                    next_cur.lenLo = wv[15:0];
                    next_cur.lenHi = wv[LEN_HI_LSB +: 16];
                end
                ETHC_REG_ITAG: next_cur.itagType = wv[15:0];
                ETHC_REG_STATUS: next_cur.bResp = AXI_OKAY;
                default: next_cur.bResp = AXI_SLVERR;
            endcase
        end
        if (cur.bValid && axiReq.bready) begin
            next_cur.bValid = 1'b0;
        end

        // AXI4-Lite read: data registered one cycle after the address.
        if (cur.rValid && axiReq.rready) begin
            next_cur.rValid = 1'b0;
        end
        if (axiReq.arvalid && axiRsp.arready) begin
            next_cur.rValid = 1'b1;
            next_cur.rData = readReg(cur, axiReq.araddr);
            next_cur.rResp = isMapped(axiReq.araddr) ? AXI_OKAY : AXI_SLVERR;
        end

        // Header parser, one byte per valid cycle.
        if (hdrIn.valid) begin
            next_cur.word = {cur.word[7:0], hdrIn.data};
            next_cur.cnt = cur.cnt + 6'h01;
            next_cur.fld = cur.fld + 3'h1;
            if (hdrIn.sof) begin
                next_cur.state = ST_ADDR;
                next_cur.cnt = 6'h01;
                next_cur.fld = 3'h1;
                next_cur.tags = 2'h0;
                next_cur.llc = 1'b0;
            end else begin
                case (cur.state)
                    ST_ADDR: begin
                        // Both addresses pass through as a pair of 6 bytes.
                        if (cur.fld == ETHC_ADDR_LAST &&
                            cur.cnt[5:3] != 3'h0) begin
                            next_cur.state = ST_TYPE;
                            next_cur.fld = 3'h0;
                        end else if (cur.fld == ETHC_ADDR_LAST) begin
                            next_cur.fld = 3'h0;
                        end
                    end
                    ST_TYPE: begin
                        if (cur.fld == ETHC_PAIR_LAST) begin
                            next_cur.fld = 3'h0;
                            if (isI) begin
                                // Outer bridged part allows one B-tag.
                                if (cur.tags > 2'h1) begin
                                    fail = 1'b1;
                                end else begin
                                    next_cur.state = ST_ITAG;
                                end
                            end else if (isC || isS) begin
                                // A tag may also follow SNAP.
                                if (cur.tags == ETHC_MAX_TAGS ||
                                    (pbb && (isC || cur.tags != 2'h0))) begin
                                    fail = 1'b1;
                                end else begin
                                    next_cur.tags = cur.tags + 2'h1;
                                    next_cur.state = ST_TAG;
                                end
                            end else if (w < ETHC_LEN_LIMIT) begin
                                if (cur.llc || pbb ||
                                    (cur.lenEnable &&
                                     (w < cur.lenLo || w > cur.lenHi))) begin
                                    fail = 1'b1;
                                end else begin
                                    next_cur.llc = 1'b1;
                                    next_cur.state = ST_LLC;
                                end
                            end else if (pbb) begin
                                fail = 1'b1;
                            end else begin
                                // Reaching here means this is the last type.
                                finish = 1'b1;
                                if (cur.etypeEnable && !cur.llc &&
                                    w != cur.etypeValue) begin
                                    fail = 1'b1;
                                end
                            end
                        end
                    end
                    ST_TAG: begin
                        if (cur.fld == ETHC_PAIR_LAST) begin
                            next_cur.fld = 3'h0;
                            next_cur.state = ST_TYPE;
                            if (cur.vlanEnable &&
                                ((vid ^ cur.vlanMatch) & cur.vlanMask)
                                != 12'h000) begin
                                fail = 1'b1;
                            end
                        end
                    end
                    ST_LLC: begin
                        if (cur.fld == ETHC_LLC_LAST) begin
                            next_cur.fld = 3'h0;
                            next_cur.state = ST_OUI;
                            if (hdrIn.data != ETHC_LLC_CTL) begin
                                fail = 1'b1;
                            end
                        end else if (hdrIn.data != ETHC_SAP_A &&
                                     hdrIn.data != ETHC_SAP_B) begin
                            fail = 1'b1;
                        end
                    end
                    ST_OUI: begin
                        if (cur.fld == ETHC_OUI_LAST) begin
                            next_cur.fld = 3'h0;
                            next_cur.state = ST_TYPE;
                            if (oui != ETHC_OUI_ZERO &&
                                oui != ETHC_OUI_ALT) begin
                                fail = 1'b1;
                            end
                        end
                    end
                    ST_ITAG: begin
                        if (cur.fld == ETHC_ITAG_LAST) begin
                            finish = 1'b1;
                        end
                    end
                    ST_IDLE, ST_DONE, ST_FAIL: begin
                        next_cur.cnt = cur.cnt;
                        next_cur.fld = cur.fld;
                    end
                    default: next_cur.state = ST_IDLE;
                endcase
                // A frame that ends inside its header cannot match.
                if (hdrIn.eof && !finish && cur.state != ST_IDLE &&
                    cur.state != ST_DONE && cur.state != ST_FAIL) begin
                    fail = 1'b1;
                end
            end
        end

        // Result toward the engine controller.
        if (finish && !fail) begin
            if (cur.nextStage == ETHC_STAGE_FIRST || !flowHit) begin
                fail = 1'b1;
            end
        end
        if (fail) begin
            next_cur.state = ST_FAIL;
            next_cur.res.valid = 1'b1;
            next_cur.res.ok = 1'b0;
            next_cur.res.noModify = 1'b1;
            next_cur.res.offset = 6'h00;
            next_cur.lastFail = 1'b1;
            next_cur.lastOk = 1'b0;
        end else if (finish) begin
            next_cur.state = ST_DONE;
            next_cur.res.valid = 1'b1;
            next_cur.res.ok = 1'b1;
            next_cur.res.offset = cur.cnt + 6'h01;
            next_cur.lastOffset = cur.cnt + 6'h01;
            next_cur.lastOk = 1'b1;
            next_cur.lastFail = 1'b0;
        end
        next_cur.res.nextStage = cur.nextStage;
        next_cur.res.sigOffset = cur.sigOffset;
    end

    // ----------------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cur <= '0;
            cur.nextStage <= ETHC_NEXT_RESET;
            cur.stagType <= ETHC_STAG_RESET;
            cur.etypeValue <= ETHC_ETYPE_RESET;
            cur.itagType <= ETHC_ITAG_RESET;
            cur.state <= ST_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

endmodule

// File: ethc_aligner_model.sv
// Purpose: Behavioural aligner that feeds header bytes to the comparator.
// Assumes: Byte 0 of each frame goes out with sof, the last with eof.
// Notes: Gap data is the byte inverted so a stale byte never repeats; A5 follows the frame.
`timescale 1ns/100ps
module ethc_aligner_model (
    input wire logic mclk,
    output ethc_pkg::ethc_byte_t hdrOut
);
    import ethc_pkg::*;
    initial hdrOut = '0;
    task automatic send(input logic [7:0] q[$], input int gap);
        for (int i = 0; i < q.size(); i++) begin
            @(posedge mclk);
            hdrOut <= '{1'b1, i == 0, i == q.size() - 1, q[i]};
            repeat (gap) begin
                @(posedge mclk);
                hdrOut <= '{1'b0, 1'b0, 1'b0, ~q[i]};
            end
        end
        @(posedge mclk);
        hdrOut <= '{1'b0, 1'b0, 1'b0, 8'hA5};
    endtask
endmodule

// File: ethc_header_comparator_checker.sv
// Purpose: Port-level assertions for the header comparator.
// Assumes: One clock, reset asynchronous and active high.
// Notes: Bound to every comparator instance.
`timescale 1ns/100ps
module ethc_header_comparator_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire ethc_pkg::ethc_byte_t hdrIn,
    input wire logic flowHit,
    input wire ethc_pkg::ethc_result_t result,
    input wire ethc_pkg::ethc_axi_req_t axiReq,
    input wire ethc_pkg::ethc_axi_rsp_t axiRsp
);
    import ethc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    property p_fail; result.valid && !result.ok |-> result.offset == 6'h00;
    endproperty
    a_fail: assert property (p_fail) else $error("offset on failure");
    property p_nomod; result.noModify |-> result.valid && !result.ok;
    endproperty
    a_nomod: assert property (p_nomod) else $error("stray no-modify");
    property p_mark; result.valid && !result.ok |-> result.noModify;
    endproperty
    a_mark: assert property (p_mark) else $error("no-modify missing");
    property p_span; result.valid && result.ok |->
        result.offset inside {[6'h0E:6'h1E]}; endproperty
    a_span: assert property (p_span) else $error("offset range");
    property p_flow; result.valid && result.ok |-> $past(flowHit);
    endproperty
    a_flow: assert property (p_flow) else $error("ok without flow");
    property p_stage; result.valid && result.ok |->
        result.nextStage != ETHC_STAGE_FIRST; endproperty
    a_stage: assert property (p_stage) else $error("stage zero ok");
    property p_rd; axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_hold; axiRsp.rvalid && !axiReq.rready |=>
        axiRsp.rvalid && $stable(axiRsp.rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data dropped");
    c_ok: cover property (result.valid && result.ok);
    c_bad: cover property (result.valid && !result.ok);
    c_sof: cover property (hdrIn.valid && hdrIn.sof);
endmodule
bind ethc_header_comparator ethc_header_comparator_checker i_chk (
    .mclk(mclk), .reset(reset), .hdrIn(hdrIn), .flowHit(flowHit),
    .result(result), .axiReq(axiReq), .axiRsp(axiRsp));

// File: ethc_header_comparator_tb_top.sv
// Purpose: Self-checking bench for the header comparator.
// Assumes: Registers set nextStage 3 and sigOffset 7 before frames.
// Notes: Handshakes are judged at the falling edge before each rise.
`timescale 1ns/100ps
module ethc_header_comparator_tb_top;
    import ethc_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic flowHit = 1'b1;
    ethc_byte_t hdrIn;
    ethc_result_t result;
    ethc_result_t gotRes;
    ethc_axi_req_t axiReq = '0;
    ethc_axi_rsp_t axiRsp;
    logic [7:0] fq[$];
    logic [31:0] d;
    logic [1:0] r;
    int gotNum = 0;
    int miscompares = 0;
    int totalChecks = 0;
    ethc_aligner_model i_ali (.mclk(mclk), .hdrOut(hdrIn));
    ethc_header_comparator i_dut (.mclk(mclk), .reset(reset),
        .hdrIn(hdrIn), .flowHit(flowHit), .result(result),
        .axiReq(axiReq), .axiRsp(axiRsp));
    initial forever #25 mclk = ~mclk;
    always @(posedge mclk) if (result.valid === 1'b1) begin
        gotRes <= result;
        gotNum <= gotNum + 1;
    end
    task automatic chk(input logic c, input string m);
        totalChecks++;
        if (c !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] wd);
        logic aw, w, b;
        @(posedge mclk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= a;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= wd;
        axiReq.wstrb <= 4'hF;
        axiReq.bready <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge mclk);
            aw = axiReq.awvalid && axiRsp.awready;
            w = axiReq.wvalid && axiRsp.wready;
            b = axiRsp.bvalid;
            r = axiRsp.bresp;
            @(posedge mclk);
            if (aw) axiReq.awvalid <= 1'b0;
            if (w) axiReq.wvalid <= 1'b0;
        end
        axiReq.bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        logic ar, b;
        @(posedge mclk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= a;
        axiReq.rready <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge mclk);
            ar = axiReq.arvalid && axiRsp.arready;
            b = axiRsp.rvalid;
            d = axiRsp.rdata;
            r = axiRsp.rresp;
            @(posedge mclk);
            if (ar) axiReq.arvalid <= 1'b0;
        end
        axiReq.rready <= 1'b0;
    endtask
    // Words after the addresses, then a payload word so eof lands late.
    task automatic fr(input logic [15:0] w[$], input logic ok,
                      input logic [5:0] off, input int gap);
        int n0;
        n0 = gotNum;
        fq = {};
        for (int i = 0; i < 12; i++) fq.push_back(8'h10 + 8'(i));
        w.push_back(16'hC0DE);
        foreach (w[i]) begin
            fq.push_back(w[i][15:8]);
            fq.push_back(w[i][7:0]);
        end
        i_ali.send(fq, gap);
        for (int n = 0; n < 40 && gotNum == n0; n++) @(posedge mclk);
        @(negedge mclk);
        chk(gotNum == n0 + 1 && gotRes.ok === ok && gotRes.offset === off
            && gotRes.noModify === !ok, "frame verdict");
        if (ok) chk(gotRes.nextStage === 3'h3
            && gotRes.sigOffset === 5'h07, "stage fields");
    endtask
    task automatic t_regs;
        axr(ETHC_REG_CTRL);
        chk(d === 32'h0000_0005 && r === AXI_OKAY, "ctrl reset");
        axr(ETHC_REG_STAG);
        chk(d === 32'h0000_8A88, "stag reset");
        axr(8'h1C);
        chk(r === AXI_SLVERR, "unmapped read");
        axw(8'h1C, 32'h0000_0000);
        chk(r === AXI_SLVERR, "unmapped write");
        axw(ETHC_REG_ETYPE, 32'h0000_88F7);
        chk(r === AXI_OKAY, "write response");
        axw(ETHC_REG_CTRL, 32'h0001_0073);
        axr(ETHC_REG_CTRL);
        chk(d === 32'h0001_0073, "ctrl readback");
    endtask
    task automatic t_type2;
        fr('{16'h88F7}, 1'b1, 6'h0E, 0);
        fr('{16'h88F5}, 1'b0, 6'h00, 2);
        fr('{16'h8100, 16'h0005, 16'h8A88, 16'h0006, 16'h88F7},
            1'b1, 6'h16, 1);
        fr('{16'h8100, 16'h0001, 16'h8100, 16'h0002, 16'h8100,
            16'h0003, 16'h88F7}, 1'b0, 6'h00, 0);
    endtask
    task automatic t_snap;
        fr('{16'h0040, 16'hAAAB, 16'h0300, 16'h0000, 16'h1234},
            1'b1, 6'h16, 0);
        fr('{16'h0040, 16'hABAA, 16'h0300, 16'h00F8, 16'h1234},
            1'b1, 6'h16, 0);
        fr('{16'h0040, 16'hAAAA, 16'h0200}, 1'b0, 6'h00, 0);
        fr('{16'h0040, 16'hAAAA, 16'h0300, 16'h0001}, 1'b0, 6'h00, 0);
        fr('{16'h8100, 16'h0001, 16'h8A88, 16'h0002, 16'h0040, 16'hAAAA,
            16'h0300, 16'h0000, 16'h1234}, 1'b1, 6'h1E, 1);
    endtask
    task automatic t_ctrl;
        @(posedge mclk);
        flowHit <= 1'b0;
        fr('{16'h88F7}, 1'b0, 6'h00, 0);
        @(posedge mclk);
        flowHit <= 1'b1;
        axw(ETHC_REG_CTRL, 32'h0001_0070);
        fr('{16'h88F7}, 1'b0, 6'h00, 0);
        axw(ETHC_REG_CTRL, 32'h0000_0073);
        fr('{16'h1234}, 1'b1, 6'h0E, 0);
    endtask
    // Bridged frames, then tag and length checks with bridging off.
    task automatic t_opt;
        axw(ETHC_REG_ITAG, 32'h0000_88E7);
        axw(ETHC_REG_CTRL, 32'h0000_1073);
        fr('{16'h88E7, 16'h0001, 16'h0002}, 1'b1, 6'h12, 0);
        fr('{16'h8A88, 16'h0005, 16'h88E7, 16'h0001, 16'h0002},
            1'b1, 6'h16, 1);
        fr('{16'h8100, 16'h0005, 16'h88E7}, 1'b0, 6'h00, 0);
        axw(ETHC_REG_VLAN, 32'h0FFF_0005);
        axw(ETHC_REG_LEN, 32'h0050_0040);
        axw(ETHC_REG_CTRL, 32'h0110_0073);
        fr('{16'h8100, 16'h0005, 16'h88F7}, 1'b1, 6'h12, 0);
        fr('{16'h8100, 16'h0006, 16'h88F7}, 1'b0, 6'h00, 0);
        fr('{16'h0060, 16'hAAAA}, 1'b0, 6'h00, 0);
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        t_regs;
        t_type2;
        t_snap;
        t_ctrl;
        t_opt;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        wrap_up;
    end
endmodule
